// ---- design/hbm_top.sv ----
// Hub bypass mode select, downstream port strap capture and interrupt pin drive
`timescale 1ns/1ns
`default_nettype none
//
// Functional notes
// - A low mode-select input puts the device in pass-through, routing the bypass port to upstream.
// - In pass-through, downstream ports 1 and 2 are left undriven.
// - In pass-through, the core logic is held in reduced power.
// - A high mode-select input returns the device to normal hub operation.
// - The data pins of ports 1 and 2 are sampled at reset release to decide port disable.
// - The reset input is active low and holds reset while low.
// - In hub mode, the interrupt pin is driven low to signal a pending interrupt.
// - Port 3, the pass-through port, has no disable strap.
// - In pass-through, any configured data-pair swap is ignored on the routed pins.

module hbm_top #(
    parameter int NPORT = hbm_pkg::HBM_NUM_STRAP_PORTS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Mode select, active low
    input wire logic bypass_sel_n,
    // Strap pins of downstream ports 1 and 2
    input wire logic [NPORT-1:0] downstream_dplus_pins,
    input wire logic [NPORT-1:0] downstream_dminus_pins,
    // Hub core requests
    input wire logic irq_req,
    input wire logic swap_cfg,
    input wire logic [NPORT-1:0] hub_drive_req,
    // Mode outputs
    output logic bypass_route_en,
    output logic core_low_power,
    output logic hub_active,
    output logic upstream_swap_en,
    // Downstream pin enables, low while driving
    output hbm_pkg::hbm_pair_oe_t [NPORT-1:0] downstream_oe_n,
    // Strap results
    output logic [NPORT-1:0] port_disabled,
    output logic strap_valid,
    // Interrupt pin, open drain: enable low pulls the line low
    output logic irq_oe_n
);

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [2*NPORT:0] raw_in;
    logic [2*NPORT:0] sync_in;
    logic mode_sel_n;
    logic [NPORT-1:0] dp_s;
    logic [NPORT-1:0] dm_s;

    assign raw_in = {bypass_sel_n, downstream_dplus_pins, downstream_dminus_pins};

    // Resets to hub mode side and to not-tied, so a short reset strap reads enabled
    hbm_sync #(
        .WIDTH(2 * NPORT + 1),
        .RST_VAL({1'b1, {(2 * NPORT){1'b0}}})
    ) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .din(raw_in),
        .dout(sync_in)
    );

    assign mode_sel_n = sync_in[2*NPORT];
    assign dp_s = sync_in[2*NPORT-1:NPORT];
    assign dm_s = sync_in[NPORT-1:0];

    // ------------------------------------------------------------
    // Mode and strap state machine
    // ------------------------------------------------------------
    hbm_pkg::hbm_state_t state;
    hbm_pkg::hbm_state_t next_state;
    logic [NPORT-1:0] next_disabled;
    logic strap_take;
    logic strap_ready;
    logic [1:0] strap_cnt;
    logic [1:0] next_strap_cnt;
    logic [NPORT-1:0] strap_tied;

    // Both pins high means the board tied the pair to the 3.3 V rail
    assign strap_tied = dp_s & dm_s;
    // The synchroniser shows its reset value for two edges after release, so the
    // strap waits until the pin level present at release has reached its output
    assign strap_ready = (strap_cnt == 2'(hbm_pkg::HBM_SYNC_STAGES));
    assign next_strap_cnt = ((state == hbm_pkg::HBM_ST_STRAP) && !strap_ready)
        ? strap_cnt + 2'd1 : strap_cnt;
    assign strap_take = (state == hbm_pkg::HBM_ST_STRAP) && strap_ready;
    assign next_disabled = strap_take ? strap_tied : port_disabled;

    // Mode follows the synchronised select pin once the strap is in
    always_comb begin
        next_state = state;
        case (state)
            hbm_pkg::HBM_ST_STRAP: begin
                if (strap_ready) begin
                    next_state = mode_sel_n ? hbm_pkg::HBM_ST_HUB : hbm_pkg::HBM_ST_BYPASS;
                end
            end
            hbm_pkg::HBM_ST_HUB: begin
                if (!mode_sel_n) begin
                    next_state = hbm_pkg::HBM_ST_BYPASS;
                end
            end
            hbm_pkg::HBM_ST_BYPASS: begin
                if (mode_sel_n) begin
                    next_state = hbm_pkg::HBM_ST_HUB;
                end
            end
            default: begin
                next_state = hbm_pkg::HBM_ST_STRAP;
            end
        endcase
    end

    // State and latched strap; reset is asynchronous and active low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= hbm_pkg::HBM_ST_STRAP;
            strap_cnt <= '0;
            port_disabled <= NPORT'(hbm_pkg::HBM_DISABLE_RST);
            strap_valid <= 1'b0;
        end else begin
            state <= next_state;
            strap_cnt <= next_strap_cnt;
            port_disabled <= next_disabled;
            strap_valid <= strap_valid | strap_take;
        end
    end

    // ------------------------------------------------------------
    // Output decode
    // ------------------------------------------------------------
    logic in_bypass;
    logic in_hub;
    logic [NPORT-1:0] next_drive;
    hbm_pkg::hbm_pair_oe_t [NPORT-1:0] next_oe_n;

    assign in_bypass = (next_state == hbm_pkg::HBM_ST_BYPASS);
    assign in_hub = (next_state == hbm_pkg::HBM_ST_HUB);
    // Disabled or bypassed ports never drive; pass-through floats ports 1 and 2
    assign next_drive = hub_drive_req & ~next_disabled & {NPORT{in_hub}};

    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            next_oe_n[i].dplus_oe_n = ~next_drive[i];
            next_oe_n[i].dminus_oe_n = ~next_drive[i];
        end
    end

    // Registered outputs; looking at next_state saves a cycle of latency
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bypass_route_en <= 1'b0;
            core_low_power <= 1'b0;
            hub_active <= 1'b0;
            upstream_swap_en <= 1'b0;
            downstream_oe_n <= '1;
            irq_oe_n <= hbm_pkg::HBM_IRQ_N_RST;
        end else begin
            bypass_route_en <= in_bypass;
            core_low_power <= in_bypass;
            hub_active <= in_hub;
            upstream_swap_en <= swap_cfg & ~in_bypass;
            downstream_oe_n <= next_oe_n;
            irq_oe_n <= ~(irq_req & in_hub);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_sel_low_held;
        !sync_in[2*NPORT] [*2];
    endsequence

    property p_bypass_enter;
        @(posedge clk_sys) disable iff (!resetn)
        s_sel_low_held |-> bypass_route_en && core_low_power;
    endproperty
    a_bypass_enter: assert property (p_bypass_enter) else $error("bypass not entered");

    property p_ports_float;
        @(posedge clk_sys) disable iff (!resetn)
        bypass_route_en |-> downstream_oe_n == '1;
    endproperty
    a_ports_float: assert property (p_ports_float) else $error("port driven in bypass");

    property p_low_power;
        @(posedge clk_sys) disable iff (!resetn)
        core_low_power == bypass_route_en;
    endproperty
    a_low_power: assert property (p_low_power) else $error("power state mismatch");

    property p_hub_return;
        @(posedge clk_sys) disable iff (!resetn)
        (strap_valid && mode_sel_n) [*2] |-> hub_active && !bypass_route_en;
    endproperty
    a_hub_return: assert property (p_hub_return) else $error("hub mode not resumed");

    property p_strap_take;
        @(posedge clk_sys) disable iff (!resetn)
        strap_take |=> port_disabled == $past(strap_tied);
    endproperty
    a_strap_take: assert property (p_strap_take) else $error("strap not captured");

    // Neither hub_active nor bypass_route_en may come up before the strap has been taken
    property p_strap_wait;
        @(posedge clk_sys) disable iff (!resetn)
        !strap_valid |-> !hub_active && !bypass_route_en;
    endproperty
    a_strap_wait: assert property (p_strap_wait) else $error("mode before strap");

    property p_strap_hold;
        @(posedge clk_sys) disable iff (!resetn)
        strap_valid |=> $stable(port_disabled);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

    property p_reset_state;
        @(posedge clk_sys)
        !resetn |=> !strap_valid && irq_oe_n && downstream_oe_n == '1 && !hub_active
            && !bypass_route_en;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    property p_irq_low;
        @(posedge clk_sys) disable iff (!resetn)
        !irq_oe_n |-> $past(irq_req) && hub_active;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq without request");

    property p_swap_ignored;
        @(posedge clk_sys) disable iff (!resetn)
        bypass_route_en |-> !upstream_swap_en;
    endproperty
    a_swap_ignored: assert property (p_swap_ignored) else $error("swap active in bypass");

    property p_disabled_float;
        @(posedge clk_sys) disable iff (!resetn)
        strap_valid |-> (port_disabled & ~{downstream_oe_n[1].dplus_oe_n,
                                           downstream_oe_n[0].dplus_oe_n}) == '0;
    endproperty
    a_disabled_float: assert property (p_disabled_float) else $error("disabled port driven");

endmodule : hbm_top

`default_nettype wire

// ---- design/hbm_pkg.sv ----
// Package with shared constants and carrier types for the hub mode and strap block
`default_nettype none
package hbm_pkg;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int HBM_NUM_STRAP_PORTS = 2;
    localparam logic [1:0] HBM_DISABLE_RST = 2'h0;
    localparam logic HBM_IRQ_N_RST = 1'b1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int HBM_CLK_PERIOD_NS = 4;
    localparam int HBM_SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HBM_ST_STRAP,
        HBM_ST_HUB,
        HBM_ST_BYPASS
    } hbm_state_t;

    // Pin enables for one downstream data pair
    typedef struct packed {
        logic dplus_oe_n;
        logic dminus_oe_n;
    } hbm_pair_oe_t;

endpackage : hbm_pkg

`default_nettype wire

// ---- design/hbm_sync.sv ----
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ns
`default_nettype none

module hbm_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule : hbm_sync

`default_nettype wire

// ---- testbench/hbm_host_model.sv ----
// Board and system-processor model that drives the mode pin and the strap pins
`timescale 1ns/1ns
`default_nettype none

module hbm_host_model #(
    parameter bit HAS_BYPASS = 1'b1
) (
    // Requests from the bench
    input wire logic want_bypass,
    input wire logic [1:0] strap_dis,
    input wire logic [1:0] half_strap,
    // Pins toward the block
    output logic bypass_sel_n,
    output logic [1:0] dplus,
    output logic [1:0] dminus
);
    // --------------------------------------------------------
    // Pin levels
    // --------------------------------------------------------
    // Parts without pass-through keep the pin high at all times
    assign bypass_sel_n = !(want_bypass && HAS_BYPASS);
    // A disabled port has both data pins tied to the rail; a half strap raises D+ only; others sit at the pull-down level
    assign dplus = strap_dis | half_strap;
    assign dminus = strap_dis;
endmodule : hbm_host_model

`default_nettype wire

// ---- testbench/test_hbm_top.sv ----
// Self-checking bench for the hub mode and strap block
`timescale 1ns/1ns
`default_nettype none

module test_hbm_top;
    // --------------------------------------------------------
    // Signals
    // --------------------------------------------------------
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic want_bypass = 1'b0;
    logic [1:0] strap_dis = 2'h1;
    logic [1:0] half_strap = 2'h2;
    logic irq_req = 1'b0;
    logic swap_cfg = 1'b0;
    logic [1:0] hub_drive_req = 2'h0;
    wire logic bypass_sel_n;
    wire logic [1:0] dp;
    wire logic [1:0] dm;
    logic bypass_route_en, core_low_power, hub_active, upstream_swap_en, strap_valid, irq_oe_n;
    hbm_pkg::hbm_pair_oe_t [1:0] downstream_oe_n;
    logic [1:0] port_disabled;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    // Clock and a ceiling well above the few dozen cycles the tests need
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            report_and_stop();
        end
    end

    hbm_host_model u_hbm_host_model (.want_bypass(want_bypass), .strap_dis(strap_dis),
        .half_strap(half_strap), .bypass_sel_n(bypass_sel_n), .dplus(dp), .dminus(dm));

    hbm_top u_hbm_top (.clk_sys(clk_sys), .resetn(resetn), .bypass_sel_n(bypass_sel_n),
        .downstream_dplus_pins(dp), .downstream_dminus_pins(dm), .irq_req(irq_req),
        .swap_cfg(swap_cfg), .hub_drive_req(hub_drive_req), .bypass_route_en(bypass_route_en),
        .core_low_power(core_low_power), .hub_active(hub_active),
        .upstream_swap_en(upstream_swap_en), .downstream_oe_n(downstream_oe_n),
        .port_disabled(port_disabled), .strap_valid(strap_valid), .irq_oe_n(irq_oe_n));

    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_cyc

    task automatic report_and_stop();
        $display("Counts: %0d checks, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    // Reset outputs, then strap capture: port 1 fully strapped, port 2 only half
    task automatic test_reset_strap();
        wait_cyc(3);
        check("oe_n in reset", 4'hf, downstream_oe_n);
        check("irq in reset", 4'h1, irq_oe_n);
        resetn = 1'b1;
        // Two edges for the pins to cross the synchroniser, taken at the third
        wait_cyc(2);
        check("strap wait", 4'h0, strap_valid);
        wait_cyc(1);
        check("strap_valid", 4'h1, strap_valid);
        check("strap", 4'h1, port_disabled);
        check("hub after strap", 4'h1, hub_active);
        // Straps move after release; the latched value must not follow
        strap_dis = 2'h2;
        half_strap = 2'h0;
        wait_cyc(5);
        check("strap held", 4'h1, port_disabled);
        $display("done: reset and strap");
    endtask : test_reset_strap

    // Pass-through entry with exact latency; hub requests must have no effect
    task automatic test_bypass();
        swap_cfg = 1'b1;
        hub_drive_req = 2'h3;
        want_bypass = 1'b1;
        wait_cyc(2);
        check("hub before sync", 4'h1, hub_active);
        wait_cyc(1);
        check("route", 4'h1, bypass_route_en);
        check("hub off", 4'h0, hub_active);
        check("oe_n", 4'hf, downstream_oe_n);
        check("low power", 4'h1, core_low_power);
        check("swap", 4'h0, upstream_swap_en);
        irq_req = 1'b1;
        wait_cyc(1);
        check("irq ignored", 4'h1, irq_oe_n);
        $display("done: bypass");
    endtask : test_bypass

    // Return to hub mode; disabled port stays undriven, interrupt pulls low
    task automatic test_hub();
        irq_req = 1'b0;
        want_bypass = 1'b0;
        wait_cyc(3);
        check("route off", 4'h0, bypass_route_en);
        check("hub on", 4'h1, hub_active);
        check("power up", 4'h0, core_low_power);
        check("swap on", 4'h1, upstream_swap_en);
        check("oe_n hub", 4'h3, downstream_oe_n);
        irq_req = 1'b1;
        wait_cyc(1);
        check("irq low", 4'h0, irq_oe_n);
        $display("done: hub");
    endtask : test_hub

    // Mid-run reset with pass-through requested: new strap is taken, start is in pass-through
    task automatic test_rereset();
        irq_req = 1'b0;
        want_bypass = 1'b1;
        resetn = 1'b0;
        wait_cyc(1);
        check("oe_n in reset 2", 4'hf, downstream_oe_n);
        check("hub in reset", 4'h0, hub_active);
        check("irq in reset 2", 4'h1, irq_oe_n);
        resetn = 1'b1;
        wait_cyc(2);
        check("strap wait 2", 4'h0, strap_valid);
        check("route in strap", 4'h0, bypass_route_en);
        wait_cyc(1);
        check("strap 2", 4'h2, port_disabled);
        check("route at start", 4'h1, bypass_route_en);
        check("oe_n bypass 2", 4'hf, downstream_oe_n);
        $display("done: second reset");
    endtask : test_rereset

    initial begin
        test_reset_strap();
        test_bypass();
        test_hub();
        test_rereset();
        report_and_stop();
    end
endmodule : test_hbm_top

`default_nettype wire
